// ==== verification/fpe_controller_properties.sv ====
// checker: port properties of the flash controller
`timescale 1ns/1ps
module fpe_chk
  import fpe_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       ctl_wr,
  input wire logic       timing_wr,
  input wire logic       xmove_wr,
  input wire fpe_req_s   xmove_req,
  input wire logic       xram_wr,
  input wire logic       core_hold,
  input wire logic       flash_write_enable,
  input wire logic       sector_erase_enable,
  input wire logic [3:0] flash_timing_register
);
  logic hold_q;
  logic idle;
  logic go;
  // idle excludes the cycle the hold drops, so a request in that cycle is not checked
  always_ff @(posedge sys_clk) hold_q <= core_hold;
  assign idle = !core_hold && !hold_q;
  assign go = idle && xmove_wr && xmove_req.addr < MEM_BYTES && flash_write_enable;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  we_kept_a: assert property (!ctl_wr |=> $stable(flash_write_enable))
    else $error("write enable moved");
  ee_kept_a: assert property (!ctl_wr |=> $stable(sector_erase_enable))
    else $error("erase enable moved");
  prescale_kept_a: assert property (!timing_wr |=> $stable(flash_timing_register))
    else $error("prescaler moved");
  xram_route_a: assert property (idle && xmove_wr && !flash_write_enable |=> xram_wr && !core_hold)
    else $error("xram write lost");
  flash_take_a: assert property (go |=> core_hold && !xram_wr)
    else $error("flash write not held");
  prog_time_a: assert property (go && !sector_erase_enable
    |=> core_hold [*8] ##[1:700] !core_hold) else $error("program time wrong");
  erase_long_a: assert property (go && sector_erase_enable |=> ##300 core_hold)
    else $error("erase too short");
  busy_quiet_a: assert property (core_hold |-> !xram_wr)
    else $error("xram write while busy");
endmodule
bind fpe_controller fpe_chk fpe_chk_i (.sys_clk, .reset_n, .ctl_wr, .timing_wr, .xmove_wr, .xmove_req,
  .xram_wr, .core_hold, .flash_write_enable, .sector_erase_enable, .flash_timing_register);

// ==== verification/fpe_controller_test.sv ====
// testbench: flash controller against a byte-array reference model
`timescale 1ns/1ps
module fpe_controller_test;
  import fpe_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  ctl_wr, ctl_write_enable, ctl_erase_enable, timing_wr, rd_en;
  logic                  xmove_wr, tport_wr, xram_wr, core_hold, flash_write_enable, sector_erase_enable;
  logic [PRESCALE_W-1:0] timing_prescaler_value, flash_timing_register;
  logic [ADDR_W-1:0]     rd_addr;
  logic [DATA_W-1:0]     rd_data;
  fpe_req_s              xmove_req, tport_req, xram_req, xram_seen;
  logic [DATA_W-1:0]     mem [int];
  int                    error_cnt = 0;
  int                    checks_done = 0;
  int                    xram_cnt = 0;
  int                    hold_cnt = 0;
  int                    a;
  bit                    we, ee;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (core_hold === 1'b1) hold_cnt++;
    if (xram_wr === 1'b1) begin
      xram_cnt++;
      xram_seen = xram_req;
    end
  end
  fpe_controller fpe_controller_i (.sys_clk, .reset_n, .ctl_wr, .ctl_write_enable, .ctl_erase_enable, .timing_wr,
    .timing_prescaler_value, .xmove_wr, .xmove_req, .tport_wr, .tport_req, .rd_en, .rd_addr, .rd_data, .xram_wr,
    .xram_req, .core_hold, .flash_write_enable, .sector_erase_enable, .flash_timing_register);
  fpe_core_model fpe_core_model_i (.sys_clk, .core_hold, .xmove_req, .tport_req, .xmove_wr, .tport_wr);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ctl(input bit w, input bit e);
    @(negedge sys_clk);
    {ctl_wr, ctl_write_enable, ctl_erase_enable} = {1'b1, w, e};
    {we, ee} = {w, e};
    @(negedge sys_clk);
    ctl_wr = 1'b0;
  endtask
  task automatic rd(input int x);
    @(negedge sys_clk);
    {rd_en, rd_addr} = {1'b1, x[ADDR_W-1:0]};
    @(negedge sys_clk);
    rd_en = 1'b0;
    chk("rd_data", mem[x], rd_data);
  endtask
  task automatic op(input bit tp, input int x, input int d, input bit wt);
    fpe_core_model_i.send(tp, x, d, wt);
    if (we && ee && !tp) begin
      for (int i = 0; i < SECTOR_BYTES; i++) mem[x - x % SECTOR_BYTES + i] = ERASED_BYTE;
    end else if (we || tp) begin
      mem[x] = mem.exists(x) ? mem[x] & d[DATA_W-1:0] : d[DATA_W-1:0];
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 20000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {ctl_wr, ctl_write_enable, ctl_erase_enable, timing_wr, rd_en, rd_addr} = '0;
    timing_prescaler_value = 4'hA;
    void'($urandom(21524));
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    chk("timing", PRESCALE_RST, flash_timing_register);
    chk("enables", 0, {flash_write_enable, sector_erase_enable});
    @(negedge sys_clk);
    {timing_wr, timing_prescaler_value} = {1'b1, 4'h0};
    @(negedge sys_clk);
    timing_wr = 1'b0;
    chk("timing", 0, flash_timing_register);
    ctl(1, 1);
    op(0, 100, $urandom, 1);
    op(0, 8200, $urandom, 1);
    chk("enables", 3, {flash_write_enable, sector_erase_enable});
    for (int i = 0; i < 640; i++) rd(i < 512 ? i : 7680 + i);
    ctl(1, 0);
    for (int i = 0; i < 16; i++) begin
      a = $urandom % 2 ? 8192 + $urandom % 128 : $urandom % 512;
      op(i % 4 == 3, a, $urandom, 1);
      op(0, a, $urandom, 1);
      rd(a);
    end
    a = $urandom % 512;
    op(0, a, 8'h0F, 0);
    fpe_core_model_i.send(0, a ^ 1, 0, 1);
    rd(a ^ 1);
    rd(a);
    ctl(0, 0);
    op(0, a, 8'h00, 1);
    op(1, a ^ 2, 8'h3C, 1);
    rd(a);
    rd(a ^ 2);
    chk("xram_cnt", 1, xram_cnt);
    chk("xram_req", {a[ADDR_W-1:0], 8'h00}, xram_seen);
    @(negedge sys_clk);
    {timing_wr, timing_prescaler_value} = {1'b1, PRESCALE_RST};
    @(negedge sys_clk);
    timing_wr = 1'b0;
    chk("timing", PRESCALE_RST, flash_timing_register);
    ctl(1, 0);
    hold_cnt = 0;
    op(0, a ^ 2, $urandom, 1);
    chk("hold_cycles", STEP_CYCLES * (int'(PRESCALE_RST) + 1) + 2, hold_cnt);
    rd(a ^ 2);
    give_verdict();
  end
endmodule

// ==== verification/fpe_core_model.sv ====
// model: core and test port issuing one-byte flash writes
`timescale 1ns/1ps
module fpe_core_model
  import fpe_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic core_hold,
  output fpe_req_s  xmove_req,
  output fpe_req_s  tport_req,
  output logic      xmove_wr,
  output logic      tport_wr
);
  initial begin
    {xmove_wr, tport_wr, xmove_req, tport_req} = '0;
  end
  // one byte per request; with wt set, next one only after the hold drops plus an idle cycle
  task automatic send(input bit tp, input int a, input int d, input bit wt);
    @(negedge sys_clk);
    tport_wr = tp;
    xmove_wr = !tp;
    tport_req = '{a[ADDR_W-1:0], d[DATA_W-1:0]};
    xmove_req = tport_req;
    @(negedge sys_clk);
    {xmove_wr, tport_wr} = 2'b00;
    // released operands are inverted so a stale value never reads as live
    xmove_req = ~xmove_req;
    tport_req = ~tport_req;
    repeat (2) @(negedge sys_clk);
    for (int n = 0; n < 20000 && wt && core_hold !== 1'b0; n++) @(negedge sys_clk);
    @(negedge sys_clk);
  endtask
endmodule

// ==== verilog/fpe_controller.sv ====
// module: flash program and sector erase controller with byte array
// Operation
// [R1] 8 KB plus 128 B, byte programmable
// [R2] program ANDs old byte with written data
// [R3] erase sets whole 512-byte sector to FF
// [R4] writes reach flash only when write-enabled; test-port writes here program regardless of write enable
// [R5] write enable cleared only by software
// [R6] erase plus write enable erases sector
// [R7] erase enable held until software clears
// [R8] hardware times operations from prescaler value
// [R9] software follows documented reprogram order
// [R10] erase before write; blank part via test port
// [R11] core held busy until operation ends
`timescale 1ns/1ps
module fpe_controller
  import fpe_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  ctl_wr,
  input  wire logic                  ctl_write_enable,
  input  wire logic                  ctl_erase_enable,
  input  wire logic                  timing_wr,
  input  wire logic [PRESCALE_W-1:0] timing_prescaler_value,
  input  wire logic                  xmove_wr,
  input  wire fpe_req_s              xmove_req,
  input  wire logic                  tport_wr,
  input  wire fpe_req_s              tport_req,
  input  wire logic                  rd_en,
  input  wire logic [ADDR_W-1:0]     rd_addr,
  output logic [DATA_W-1:0]          rd_data,
  output logic                       xram_wr,
  output fpe_req_s                   xram_req,
  output logic                       core_hold,
  output logic                       flash_write_enable,
  output logic                       sector_erase_enable,
  output logic [PRESCALE_W-1:0]      flash_timing_register
);
  import fpe_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // control bits
  logic                  we_q;
  logic                  we_d;
  logic                  ee_q;
  logic                  ee_d;
  logic [PRESCALE_W-1:0] pre_q;
  logic [PRESCALE_W-1:0] pre_d;

  always_comb begin
    we_d  = we_q;
    ee_d  = ee_q;
    pre_d = pre_q;
    if (ctl_wr) begin
      we_d = ctl_write_enable;    // [R5]
      ee_d = ctl_erase_enable;    // [R7]
    end
    if (timing_wr) begin
      pre_d = timing_prescaler_value;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      we_q  <= 1'b0;
      ee_q  <= 1'b0;
      pre_q <= PRESCALE_RST;
    end else begin
      we_q  <= we_d;
      ee_q  <= ee_d;
      pre_q <= pre_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  logic [DATA_W-1:0]   mem [MEM_BYTES];
  fpe_state_e          st_q;
  fpe_state_e          st_d;
  fpe_req_s            op_q;
  fpe_req_s            op_d;
  logic [OP_CNT_W-1:0] steps_q;
  logic [OP_CNT_W-1:0] steps_d;
  logic [SECTOR_W-1:0] ofs_q;
  logic [SECTOR_W-1:0] ofs_d;
  logic                hold_q;
  logic                hold_d;
  logic                xr_q;
  logic                xr_d;
  fpe_req_s            xreq_q;
  fpe_req_s            xreq_d;
  logic [DATA_W-1:0]   rdat_q;
  logic [DATA_W-1:0]   rdat_d;
  logic                step;
  logic                run;
  logic                mem_we;
  logic [ADDR_W-1:0]   mem_addr;
  logic [DATA_W-1:0]   mem_wdata;
  logic [ADDR_W-1:0]   erase_addr;
  logic                in_range;

  assign run        = (st_q == FPE_PROGRAM) || (st_q == FPE_ERASE);
  assign erase_addr = {op_q.addr[ADDR_W-1:SECTOR_W], ofs_q};
  assign in_range   = 32'(xmove_req.addr) < MEM_BYTES;

  fpe_step_timer u_timer (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .run      (run),
    .prescale (pre_q),
    .step     (step)
  );

  always_comb begin
    st_d      = st_q;
    op_d      = op_q;
    steps_d   = steps_q;
    ofs_d     = ofs_q;
    hold_d    = hold_q;
    xr_d      = 1'b0;
    xreq_d    = xmove_req;
    mem_we    = 1'b0;
    mem_addr  = op_q.addr;
    mem_wdata = mem[op_q.addr] & op_q.data;   // [R2]
    case (st_q)
      FPE_IDLE: begin
        if (xmove_wr && we_q && in_range) begin   // [R4]
          op_d    = xmove_req;
          hold_d  = 1'b1;                         // [R11]
          steps_d = '0;
          ofs_d   = '0;
          st_d    = ee_q ? FPE_ERASE : FPE_PROGRAM;   // [R6]
        end else if (xmove_wr) begin
          xr_d = 1'b1;                            // [R4]
        end else if (tport_wr && 32'(tport_req.addr) < MEM_BYTES) begin
          op_d    = tport_req;                    // [R1]
          // busy is shown for test-port writes too, so no core write slips in
          hold_d  = 1'b1;                         // [R11]
          steps_d = '0;
          st_d    = FPE_PROGRAM;
        end
      end
      FPE_PROGRAM: begin
        if (step) begin                           // [R8]
          mem_we = 1'b1;
          st_d   = FPE_WAIT;
        end
      end
      FPE_ERASE: begin
        // one step per prescaled tick, cells cleared in a sweep at the end
        if (step) begin
          if (steps_q == OP_CNT_W'(ERASE_MULT - 1)) begin   // [R8]
            st_d = FPE_WAIT;
          end else begin
            steps_d = steps_q + 1'b1;
          end
        end
        if (st_d == FPE_WAIT || ofs_q != '0) begin
          mem_we    = 1'b1;                       // [R3]
          mem_addr  = erase_addr;
          mem_wdata = ERASED_BYTE;
          st_d      = (ofs_q == SECTOR_LAST) ? FPE_WAIT : FPE_ERASE;
          ofs_d     = ofs_q + 1'b1;
        end
      end
      FPE_WAIT: begin
        hold_d = 1'b0;                            // [R11]
        st_d   = FPE_IDLE;
      end
      default: begin
        st_d = FPE_IDLE;
      end
    endcase
    rdat_d = rd_en ? mem[rd_addr] : rdat_q;
  end

  // sector sweep runs 512 cycles, starting in the cycle of the final timed step; the core stays
  // held through the sweep, so the busy time grows by 511 cycles
  always_ff @(posedge sys_clk) begin
    // the extra area's sector reaches past the array; those cells are dropped
    if (mem_we && (32'(mem_addr) < MEM_BYTES)) begin
      mem[mem_addr] <= mem_wdata;                 // [R1]
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= FPE_IDLE;
      op_q    <= '0;
      steps_q <= '0;
      ofs_q   <= '0;
      hold_q  <= 1'b0;
      xr_q    <= 1'b0;
      xreq_q  <= '0;
      rdat_q  <= '0;
    end else begin
      st_q    <= st_d;
      op_q    <= op_d;
      steps_q <= steps_d;
      ofs_q   <= ofs_d;
      hold_q  <= hold_d;
      xr_q    <= xr_d;
      xreq_q  <= xreq_d;
      rdat_q  <= rdat_d;
    end
  end

  assign rd_data               = rdat_q;
  assign xram_wr               = xr_q;
  assign xram_req              = xreq_q;
  assign core_hold             = hold_q;
  assign flash_write_enable    = we_q;
  assign sector_erase_enable   = ee_q;
  assign flash_timing_register = pre_q;
endmodule

// ==== verilog/fpe_pkg.sv ====
// package: constants and carriers for the flash program/erase controller
package fpe_pkg;
  localparam int unsigned ADDR_W      = 14;   // 8 KB main + 128 B extra space
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned MAIN_BYTES  = 8192;
  localparam int unsigned EXTRA_BYTES = 128;
  localparam int unsigned MEM_BYTES   = MAIN_BYTES + EXTRA_BYTES;
  localparam int unsigned SECTOR_BYTES = 512;
  localparam int unsigned SECTOR_W    = 9;    // byte offset bits in a sector
  localparam int unsigned PRESCALE_W  = 4;
  localparam int unsigned SYS_CLK_MHZ = 40;
  // base program time in ns per prescaler step; the erase takes a multiple
  localparam int unsigned STEP_TIME_NS = 1000;
  localparam int unsigned STEP_CYCLES  = (STEP_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned ERASE_MULT   = 16;
  // must hold STEP_CYCLES * 16 - 1 for the slowest prescaler setting
  localparam int unsigned STEP_CNT_W   = 10;
  localparam int unsigned OP_CNT_W     = 9;
  localparam logic [DATA_W-1:0]  ERASED_BYTE = 8'hFF;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 4'hF;
  localparam logic [SECTOR_W-1:0] SECTOR_LAST = 9'h1FF;

  typedef enum logic [1:0] {
    FPE_IDLE    = 2'b00,
    FPE_PROGRAM = 2'b01,
    FPE_ERASE   = 2'b10,
    FPE_WAIT    = 2'b11
  } fpe_state_e;

  // one external-move write request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpe_req_s;
endpackage

// ==== verilog/fpe_step_timer.sv ====
// module: prescaled step pulse generator for flash operation timing
`timescale 1ns/1ps
module fpe_step_timer
  import fpe_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic                  run,
  input  wire logic [PRESCALE_W-1:0] prescale,
  output logic                       step
);
  import fpe_pkg::*;

  logic [STEP_CNT_W-1:0] cnt_q;
  logic [STEP_CNT_W-1:0] cnt_d;
  logic                  step_q;
  logic                  step_d;
  logic [STEP_CNT_W-1:0] limit;

  // a larger prescaler value stretches every step
  assign limit = STEP_CNT_W'(STEP_CYCLES * (32'(prescale) + 32'd1) - 32'd1);

  always_comb begin
    cnt_d  = cnt_q;
    step_d = 1'b0;
    if (!run) begin
      cnt_d = '0;
    end else if (cnt_q >= limit) begin
      cnt_d  = '0;
      step_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q  <= '0;
      step_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      step_q <= step_d;
    end
  end

  assign step = step_q;
endmodule
